// [rtl/pbc_override.sv]
// Alternate-function override logic for ports B and C
`timescale 1ns/1ps
module pbc_override (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Port registers
  input wire logic [7:0] i_port_b_out,
  input wire logic [7:0] i_port_b_dir,
  input wire logic [7:0] i_port_c_out,
  input wire logic [7:0] i_port_c_dir,
  input wire logic i_global_pullup_disable,
  // Pins
  input wire logic [7:0] i_pin_b,
  input wire logic [7:0] i_pin_c,
  // Control bits
  input wire logic i_spi_enable_bit,
  input wire logic i_spi_master_select,
  input wire logic i_usart_sync_mode,
  input wire logic i_external_interrupt_two_en,
  input wire logic [7:0] i_pcmask_b,
  input wire logic [7:0] i_pcmask_c,
  input wire logic i_pin_change_group1_enable,
  input wire logic i_pin_change_group2_enable,
  input wire logic i_async_timer_clock_select,
  input wire logic i_external_clock_select,
  input wire logic i_test_port_enable,
  input wire logic i_two_wire_enable,
  input wire logic i_oc0a_enable,
  input wire logic i_oc0b_enable,
  // Peripheral outputs
  input wire logic i_spi_sck_out,
  input wire logic i_spi_slave_out,
  input wire logic i_spi_master_out,
  input wire logic i_oc0a,
  input wire logic i_oc0b,
  input wire logic i_usart_clock_out,
  input wire logic i_tdo,
  input wire logic i_shift_active,
  input wire logic i_sda_out,
  input wire logic i_scl_out,
  // Pin drive
  output logic [7:0] o_pin_b_out,
  output logic [7:0] o_pin_b_oe,
  output logic [7:0] o_pin_b_pullup,
  output logic [7:0] o_pin_c_out,
  output logic [7:0] o_pin_c_oe,
  output logic [7:0] o_pin_c_pullup,
  // Inputs to peripherals
  output logic [7:0] o_pin_change_b,
  output logic [7:0] o_pin_change_c,
  output logic o_spi_master_in,
  output logic o_spi_slave_in,
  output logic o_spi_sck_in,
  output logic o_spi_ss_in,
  output logic o_external_interrupt_two,
  output logic o_timer0_count_input,
  output logic o_timer1_count_input,
  output logic o_usart_clock_in,
  output logic o_tdi,
  output logic o_tms,
  output logic o_tck,
  output logic o_sda_in,
  output logic o_scl_in
);
  localparam logic [7:0] RST = pbc_pkg::PBC_RESET_BYTE;
  localparam int W = pbc_pkg::PBC_WIDTH;
  // Pin groups tied to one enable; the test-port and two-wire groups are taken over as a whole
  localparam int SPI_LO = pbc_pkg::PBC_B_SS;
  localparam int SPI_N = W - SPI_LO;
  localparam int JT_HI = pbc_pkg::PBC_C_TDI;
  localparam int JT_LO = pbc_pkg::PBC_C_TCK;
  localparam int JT_N = JT_HI - JT_LO + 1;
  localparam int TW_HI = pbc_pkg::PBC_C_SDA;
  localparam int TW_LO = pbc_pkg::PBC_C_SCL;
  localparam int TW_N = TW_HI - TW_LO + 1;

  // Pins are asynchronous, so two flops before any use
  logic [7:0] b_s1_q, b_s2_q, c_s1_q, c_s2_q;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      b_s1_q <= RST;
      b_s2_q <= RST;
      c_s1_q <= RST;
      c_s2_q <= RST;
    end else begin
      b_s1_q <= i_pin_b;
      b_s2_q <= b_s1_q;
      c_s1_q <= i_pin_c;
      c_s2_q <= c_s1_q;
    end
  end

  // Override enables and values per pin
  logic [7:0] b_pullup_override_enable, b_puov, b_ddoe, b_ddov, b_pvoe, b_pvov, b_input_enable_override_enable, b_dieov;
  logic [7:0] c_pullup_override_enable, c_puov, c_ddoe, c_ddov, c_pvoe, c_pvov, c_input_enable_override_enable, c_dieov;
  logic spi_m, spi_s, pud_n;
  always_comb begin
    spi_m = i_spi_enable_bit & i_spi_master_select;
    spi_s = i_spi_enable_bit & ~i_spi_master_select;
    pud_n = ~i_global_pullup_disable;
    b_pullup_override_enable = RST;
    b_puov = RST;
    b_ddoe = RST;
    b_ddov = RST;
    b_pvoe = RST;
    b_pvov = RST;
    b_dieov = '1;
    // Forced-input SPI pins keep the port-register pull-up
    b_pullup_override_enable[pbc_pkg::PBC_B_SCK] = spi_s;
    b_pullup_override_enable[pbc_pkg::PBC_B_MISO] = spi_m;
    b_pullup_override_enable[pbc_pkg::PBC_B_MOSI] = spi_s;
    b_pullup_override_enable[pbc_pkg::PBC_B_SS] = spi_s;
    b_ddoe[pbc_pkg::PBC_B_SCK] = spi_s;
    b_ddoe[pbc_pkg::PBC_B_MISO] = spi_m;
    b_ddoe[pbc_pkg::PBC_B_MOSI] = spi_s;
    b_ddoe[pbc_pkg::PBC_B_SS] = spi_s;
    b_puov[W-1:SPI_LO] = i_port_b_out[W-1:SPI_LO] & {SPI_N{pud_n}};
    b_pvoe[pbc_pkg::PBC_B_SCK] = spi_m;
    b_pvov[pbc_pkg::PBC_B_SCK] = i_spi_sck_out;
    b_pvoe[pbc_pkg::PBC_B_MISO] = spi_s;
    b_pvov[pbc_pkg::PBC_B_MISO] = i_spi_slave_out;
    b_pvoe[pbc_pkg::PBC_B_MOSI] = spi_m;
    b_pvov[pbc_pkg::PBC_B_MOSI] = i_spi_master_out;
    b_pvoe[pbc_pkg::PBC_B_SS] = i_oc0b_enable;
    b_pvov[pbc_pkg::PBC_B_SS] = i_oc0b;
    b_pvoe[pbc_pkg::PBC_B_OCA] = i_oc0a_enable;
    b_pvov[pbc_pkg::PBC_B_OCA] = i_oc0a;
    // Clock pin only active in synchronous mode; direction bit chooses out
    if (i_usart_sync_mode && i_port_b_dir[pbc_pkg::PBC_B_T0]) begin
      b_pvoe[pbc_pkg::PBC_B_T0] = 1'b1;
      b_pvov[pbc_pkg::PBC_B_T0] = i_usart_clock_out;
    end
    b_input_enable_override_enable = i_pcmask_b & {W{i_pin_change_group1_enable}};
    b_input_enable_override_enable[pbc_pkg::PBC_B_EXTERNAL_INTERRUPT_TWO] = i_external_interrupt_two_en
      | (i_pcmask_b[pbc_pkg::PBC_B_EXTERNAL_INTERRUPT_TWO] & i_pin_change_group1_enable);

    c_pullup_override_enable = RST;
    c_puov = RST;
    c_ddoe = RST;
    c_ddov = RST;
    c_pvoe = RST;
    c_pvov = RST;
    c_input_enable_override_enable = i_pcmask_c & {W{i_pin_change_group2_enable}};
    c_dieov = '1;
    c_pullup_override_enable[pbc_pkg::PBC_C_TIMER_OSCILLATOR_PIN_TWO] = i_async_timer_clock_select & i_external_clock_select;
    c_ddoe[pbc_pkg::PBC_C_TIMER_OSCILLATOR_PIN_TWO] = i_async_timer_clock_select & i_external_clock_select;
    c_input_enable_override_enable[pbc_pkg::PBC_C_TIMER_OSCILLATOR_PIN_TWO] = (i_async_timer_clock_select & i_external_clock_select)
      | (i_pcmask_c[pbc_pkg::PBC_C_TIMER_OSCILLATOR_PIN_TWO] & i_pin_change_group2_enable);
    c_dieov[pbc_pkg::PBC_C_TIMER_OSCILLATOR_PIN_TWO] = 1'b0;
    c_pullup_override_enable[pbc_pkg::PBC_C_TOSC1] = i_async_timer_clock_select;
    c_ddoe[pbc_pkg::PBC_C_TOSC1] = i_async_timer_clock_select;
    c_input_enable_override_enable[pbc_pkg::PBC_C_TOSC1] = i_async_timer_clock_select;
    c_dieov[pbc_pkg::PBC_C_TOSC1] = i_external_clock_select;
    // Test port owns C5..C2 when enabled
    c_pullup_override_enable[JT_HI:JT_LO] = {JT_N{i_test_port_enable}};
    c_ddoe[JT_HI:JT_LO] = {JT_N{i_test_port_enable}};
    c_input_enable_override_enable[JT_HI:JT_LO] = {JT_N{i_test_port_enable}};
    c_puov[pbc_pkg::PBC_C_TDI] = 1'b1;
    c_puov[pbc_pkg::PBC_C_TMS] = 1'b1;
    c_puov[pbc_pkg::PBC_C_TCK] = 1'b1;
    c_ddov[pbc_pkg::PBC_C_TDO] = i_shift_active;
    c_pvoe[pbc_pkg::PBC_C_TDO] = i_test_port_enable;
    c_pvov[pbc_pkg::PBC_C_TDO] = i_tdo;
    c_dieov[pbc_pkg::PBC_C_TDI] = 1'b0;
    c_dieov[pbc_pkg::PBC_C_TDO] = 1'b0;
    c_dieov[pbc_pkg::PBC_C_TMS] = 1'b0;
    // Two-wire pins: direction held as input, value comes from the bus unit
    c_pullup_override_enable[TW_HI:TW_LO] = {TW_N{i_two_wire_enable}};
    c_ddoe[TW_HI:TW_LO] = {TW_N{i_two_wire_enable}};
    c_pvoe[TW_HI:TW_LO] = {TW_N{i_two_wire_enable}};
    c_puov[TW_HI:TW_LO] = i_port_c_out[TW_HI:TW_LO] & {TW_N{pud_n}};
    c_pvov[pbc_pkg::PBC_C_SDA] = i_sda_out;
    c_pvov[pbc_pkg::PBC_C_SCL] = i_scl_out;
  end

  // Generic port path with overrides, one bit per loop pass
  logic [7:0] b_out_d, b_oe_d, b_pu_d, b_die, c_out_d, c_oe_d, c_pu_d, c_die;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign b_oe_d[g] = b_ddoe[g] ? b_ddov[g] : i_port_b_dir[g];
      assign b_out_d[g] = b_pvoe[g] ? b_pvov[g] : i_port_b_out[g];
      assign b_pu_d[g] = b_pullup_override_enable[g] ? b_puov[g]
        : (i_port_b_out[g] & ~i_port_b_dir[g] & pud_n);
      assign b_die[g] = b_input_enable_override_enable[g] ? b_dieov[g] : 1'b1;
      assign c_oe_d[g] = c_ddoe[g] ? c_ddov[g] : i_port_c_dir[g];
      assign c_out_d[g] = c_pvoe[g] ? c_pvov[g] : i_port_c_out[g];
      assign c_pu_d[g] = c_pullup_override_enable[g] ? c_puov[g]
        : (i_port_c_out[g] & ~i_port_c_dir[g] & pud_n);
      assign c_die[g] = c_input_enable_override_enable[g] ? c_dieov[g] : 1'b1;
    end
  endgenerate

  logic [7:0] b_in, c_in;
  assign b_in = b_s2_q & b_die;
  assign c_in = c_s2_q & c_die;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pin_b_out <= RST;
      o_pin_b_oe <= RST;
      o_pin_b_pullup <= RST;
      o_pin_c_out <= RST;
      o_pin_c_oe <= RST;
      o_pin_c_pullup <= RST;
    end else begin
      o_pin_b_out <= b_out_d;
      o_pin_b_oe <= b_oe_d;
      o_pin_b_pullup <= b_pu_d;
      o_pin_c_out <= c_out_d;
      o_pin_c_oe <= c_oe_d;
      o_pin_c_pullup <= c_pu_d;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pin_change_b <= RST;
      o_pin_change_c <= RST;
      o_spi_master_in <= 1'b0;
      o_spi_slave_in <= 1'b0;
      o_spi_sck_in <= 1'b0;
      o_spi_ss_in <= 1'b0;
      o_external_interrupt_two <= 1'b0;
      o_timer0_count_input <= 1'b0;
      o_timer1_count_input <= 1'b0;
      o_usart_clock_in <= 1'b0;
      o_tdi <= 1'b0;
      o_tms <= 1'b0;
      o_tck <= 1'b0;
      o_sda_in <= 1'b0;
      o_scl_in <= 1'b0;
    end else begin
      o_pin_change_b <= b_in;
      o_pin_change_c <= c_in;
      o_spi_master_in <= b_in[pbc_pkg::PBC_B_MISO];
      o_spi_slave_in <= b_in[pbc_pkg::PBC_B_MOSI];
      o_spi_sck_in <= b_in[pbc_pkg::PBC_B_SCK];
      o_spi_ss_in <= b_in[pbc_pkg::PBC_B_SS];
      o_external_interrupt_two <= b_in[pbc_pkg::PBC_B_EXTERNAL_INTERRUPT_TWO];
      o_timer0_count_input <= b_in[pbc_pkg::PBC_B_T0];
      o_timer1_count_input <= b_in[pbc_pkg::PBC_B_T1];
      // Clock input gated by synchronous mode only; the direction bit is not checked
      o_usart_clock_in <= i_usart_sync_mode & b_in[pbc_pkg::PBC_B_T0];
      // Analog-style test and two-wire inputs bypass the input enable
      o_tdi <= c_s2_q[pbc_pkg::PBC_C_TDI];
      o_tms <= c_s2_q[pbc_pkg::PBC_C_TMS];
      o_tck <= c_s2_q[pbc_pkg::PBC_C_TCK];
      o_sda_in <= c_s2_q[pbc_pkg::PBC_C_SDA];
      o_scl_in <= c_s2_q[pbc_pkg::PBC_C_SCL];
    end
  end
endmodule // pbc_override

// [rtl/pbc_pkg.sv]
// Constants for the port B/C alternate-function override block
// What this block does
// - Sync USART clock on B0, direction bit selects
// - USART clock pin inactive outside synchronous mode
// - MISO built from master-in and slave-out
// - MOSI split into master-out and slave-in
// - B6 input enable forced; feeds pin-change 14
// - B5 input feeds slave-in and pin-change 13
// - B2 input enable on external_interrupt_two or pcint10
// - C7 input disabled on osc-ext-clock or pcint23
// - B0 feeds pin-change 8 and timer0 count
// - Test port on C5..C2, C5 pin-change 21
// - Two-wire data C1, clock C0, pin-change sources
// - Timer oscillator on C7/C6, pin-change 23/22
package pbc_pkg;
  localparam int PBC_WIDTH = 8;
  localparam int PBC_B_SCK = 7;
  localparam int PBC_B_MISO = 6;
  localparam int PBC_B_MOSI = 5;
  localparam int PBC_B_SS = 4;
  localparam int PBC_B_OCA = 3;
  localparam int PBC_B_EXTERNAL_INTERRUPT_TWO = 2;
  localparam int PBC_B_T1 = 1;
  localparam int PBC_B_T0 = 0;
  localparam int PBC_C_TIMER_OSCILLATOR_PIN_TWO = 7;
  localparam int PBC_C_TOSC1 = 6;
  localparam int PBC_C_TDI = 5;
  localparam int PBC_C_TDO = 4;
  localparam int PBC_C_TMS = 3;
  localparam int PBC_C_TCK = 2;
  localparam int PBC_C_SDA = 1;
  localparam int PBC_C_SCL = 0;
  localparam logic [7:0] PBC_RESET_BYTE = 8'h00;
endpackage

// [test/pbc_checker.sv]
// Concurrent checks on the port B/C override outputs
`timescale 1ns/1ps
module pbc_checker (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Controls and peripheral outputs
  input wire logic i_spi_enable_bit,
  input wire logic i_spi_master_select,
  input wire logic i_usart_sync_mode,
  input wire logic i_external_interrupt_two_en,
  input wire logic i_async_timer_clock_select,
  input wire logic i_external_clock_select,
  input wire logic i_test_port_enable,
  input wire logic i_two_wire_enable,
  input wire logic i_spi_master_out,
  input wire logic i_usart_clock_out,
  input wire logic i_tdo,
  input wire logic i_shift_active,
  input wire logic i_sda_out,
  input wire logic [7:0] i_port_b_dir,
  input wire logic [7:0] i_port_c_out,
  input wire logic [7:0] i_port_c_dir,
  input wire logic [7:0] i_pin_b,
  // Block outputs
  input wire logic [7:0] o_pin_b_out,
  input wire logic [7:0] o_pin_b_oe,
  input wire logic [7:0] o_pin_c_out,
  input wire logic [7:0] o_pin_c_oe,
  input wire logic [7:0] o_pin_c_pullup,
  input wire logic o_spi_master_in,
  input wire logic o_spi_slave_in,
  input wire logic o_external_interrupt_two,
  input wire logic o_timer0_count_input,
  input wire logic o_usart_clock_in
);
  logic mst, slv, plain;
  assign mst = i_spi_enable_bit & i_spi_master_select;
  assign slv = i_spi_enable_bit & ~i_spi_master_select;
  assign plain = ~(i_test_port_enable | i_two_wire_enable | i_async_timer_clock_select);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  AST_USART_OUT: assert property (i_usart_sync_mode && i_port_b_dir[0] |=>
    o_pin_b_oe[0] && o_pin_b_out[0] == $past(i_usart_clock_out)) else $error("xck out");
  AST_USART_OFF: assert property (!i_usart_sync_mode [*4] |-> !o_usart_clock_in)
    else $error("xck active");
  AST_MISO_IN: assert property (mst |=> !o_pin_b_oe[6]) else $error("miso driven");
  AST_MOSI_OUT: assert property (mst |=> o_pin_b_out[5] == $past(i_spi_master_out))
    else $error("mosi out");
  AST_MASTER_IN: assert property (mst [*4] |-> o_spi_master_in == $past(i_pin_b[6], 3))
    else $error("master in");
  AST_SLAVE_IN: assert property (slv [*4] |-> o_spi_slave_in == $past(i_pin_b[5], 3))
    else $error("slave in");
  AST_EXTERNAL_INTERRUPT_TWO_IN: assert property (i_external_interrupt_two_en [*4] |->
    o_external_interrupt_two == $past(i_pin_b[2], 3)) else $error("external_interrupt_two in");
  AST_OSC: assert property (i_async_timer_clock_select |=> !o_pin_c_oe[6] &&
    (!$past(i_external_clock_select) || !o_pin_c_oe[7] && !o_pin_c_pullup[7]))
    else $error("osc pins");
  AST_TIMER0_IN: assert property (i_reset_n [*4] |->
    o_timer0_count_input == $past(i_pin_b[0], 3)) else $error("t0 in");
  AST_TEST_OUT: assert property (i_test_port_enable |=> o_pin_c_pullup[5] &&
    o_pin_c_out[4] == $past(i_tdo) && o_pin_c_oe[4] == $past(i_shift_active))
    else $error("test pins");
  AST_TWO_WIRE: assert property (i_two_wire_enable |=>
    o_pin_c_out[1] == $past(i_sda_out)) else $error("sda out");
  AST_PLAIN_C: assert property (plain |=> o_pin_c_out == $past(i_port_c_out) &&
    o_pin_c_oe == $past(i_port_c_dir)) else $error("port c plain");
endmodule // pbc_checker
bind pbc_override pbc_checker chk (.*);

// [test/pbc_pad_model.sv]
// Model of one port's pads and the world outside them
`timescale 1ns/1ps
module pbc_pad_model (
  // From the override block
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_pullup,
  // Outside drivers
  input wire logic [7:0] i_ext,
  // Pad levels
  output logic [7:0] o_pin
);
  // Released pads show the pull-up or the outside level, never a stale drive
  assign o_pin = (i_oe & i_out) | (~i_oe & (i_pullup | i_ext));
endmodule // pbc_pad_model

// [test/tb.sv]
// Self-checking bench for the port B/C override block
`timescale 1ns/1ps
module tb;
  logic i_mclk, i_reset_n, i_global_pullup_disable, i_spi_enable_bit, i_spi_master_select;
  logic i_usart_sync_mode, i_external_interrupt_two_en, i_pin_change_group1_enable;
  logic i_pin_change_group2_enable, i_async_timer_clock_select, i_external_clock_select;
  logic i_test_port_enable, i_two_wire_enable, i_oc0a_enable, i_oc0b_enable, i_spi_sck_out;
  logic i_spi_slave_out, i_spi_master_out, i_oc0a, i_oc0b, i_usart_clock_out, i_tdo;
  logic i_shift_active, i_sda_out, i_scl_out, o_spi_master_in, o_spi_slave_in, o_spi_sck_in;
  logic o_spi_ss_in, o_external_interrupt_two, o_timer0_count_input, o_timer1_count_input;
  logic o_usart_clock_in, o_tdi, o_tms, o_tck, o_sda_in, o_scl_in;
  logic [7:0] i_port_b_out, i_port_b_dir, i_port_c_out, i_port_c_dir, i_pcmask_b, i_pcmask_c;
  logic [7:0] i_pin_b, i_pin_c, ext_b, ext_c, o_pin_change_b, o_pin_change_c;
  logic [7:0] o_pin_b_out, o_pin_b_oe, o_pin_b_pullup, o_pin_c_out, o_pin_c_oe, o_pin_c_pullup;
  int num_errors, comparisons;
  pbc_override dut (.*);
  pbc_pad_model pad_b (.i_out(o_pin_b_out), .i_oe(o_pin_b_oe), .i_pullup(o_pin_b_pullup),
    .i_ext(ext_b), .o_pin(i_pin_b));
  pbc_pad_model pad_c (.i_out(o_pin_c_out), .i_oe(o_pin_c_oe), .i_pullup(o_pin_c_pullup),
    .i_ext(ext_c), .o_pin(i_pin_c));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  // Pin inputs pass two sync flops and a register, so allow a spare edge
  task automatic settle;
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  task automatic spi_cases;
    @(posedge i_mclk);
    {i_spi_enable_bit, i_spi_master_select, i_spi_master_out, i_oc0a_enable, i_oc0a} <= 5'h1f;
    {i_pcmask_b, i_pin_change_group1_enable, ext_b} <= 17'h08140;
    settle;
    check(16'({o_pin_b_oe[6], o_pin_b_out[5]}), 16'h0001);
    check(16'({o_spi_master_in, o_pin_change_b[6]}), 16'h0003);
    @(posedge i_mclk);
    {i_spi_master_select, i_pcmask_b, ext_b} <= 17'h04020;
    i_port_b_out <= 8'h80;
    settle;
    check(16'({o_spi_slave_in, o_pin_change_b[5], o_spi_master_in}), 16'h0006);
    // Slave clock pin is a forced input whose pull-up still follows the port register
    check({o_pin_b_pullup, 6'h00, o_spi_sck_in, o_spi_ss_in}, 16'h8002);
  endtask
  task automatic b_inputs;
    @(posedge i_mclk);
    {i_spi_enable_bit, i_external_interrupt_two_en, i_pcmask_b, ext_b} <= 18'h10207;
    settle;
    check(16'({o_external_interrupt_two, o_timer0_count_input, o_pin_change_b[0]}),
      16'h0007);
    check(16'(o_timer1_count_input), 16'h0001);
    @(posedge i_mclk);
    {i_usart_sync_mode, i_usart_clock_out, i_port_b_dir, ext_b} <= 18'h30100;
    settle;
    check(16'({o_pin_b_oe[0], o_pin_b_out[0]}), 16'h0003);
    @(posedge i_mclk);
    {i_port_b_dir, ext_b} <= 16'h0001;
    settle;
    check(16'(o_usart_clock_in), 16'h0001);
    @(posedge i_mclk);
    i_usart_sync_mode <= 1'b0;
    settle;
    check(16'(o_usart_clock_in), 16'h0000);
  endtask
  task automatic c_cases;
    @(posedge i_mclk);
    {i_test_port_enable, i_tdo, i_shift_active, i_two_wire_enable, i_sda_out} <= 5'h1f;
    {i_pcmask_c, i_pin_change_group2_enable, ext_c} <= 17'h181e2;
    settle;
    check(16'({o_pin_c_oe[4], o_pin_c_out[4], o_pin_c_pullup[5], o_tdi}), 16'h000f);
    check(16'({o_tms, o_tck, o_scl_in}), 16'h0006);
    check(16'({o_pin_c_out[1:0], o_sda_in}), 16'h0005);
    // High C7 pad must not reach the pin-change logic while its input is disabled
    check(16'(o_pin_change_c), 16'h0046);
    @(posedge i_mclk);
    {i_test_port_enable, i_two_wire_enable, i_async_timer_clock_select} <= 3'h1;
    {i_external_clock_select, i_port_c_dir} <= 9'h1ff;
    settle;
    check(16'({o_pin_c_oe[7:6], o_pin_change_c[7:6]}), 16'h0001);
    @(posedge i_mclk);
    {i_async_timer_clock_select, i_port_c_out, i_port_c_dir} <= 17'h0a53c;
    settle;
    check({o_pin_c_out, o_pin_c_oe}, 16'ha53c);
  endtask
  task automatic summarize;
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  initial begin
    {i_port_b_out, i_port_b_dir, i_port_c_out, i_port_c_dir, i_pcmask_b, i_pcmask_c} = '0;
    {ext_b, ext_c, i_global_pullup_disable, i_spi_enable_bit, i_spi_master_select} = '0;
    {i_usart_sync_mode, i_external_interrupt_two_en, i_pin_change_group1_enable} = '0;
    {i_pin_change_group2_enable, i_async_timer_clock_select, i_external_clock_select} = '0;
    {i_test_port_enable, i_two_wire_enable, i_oc0a_enable, i_oc0b_enable, i_spi_sck_out} = '0;
    {i_spi_slave_out, i_spi_master_out, i_oc0a, i_oc0b, i_usart_clock_out, i_tdo} = '0;
    {i_shift_active, i_sda_out, i_scl_out, i_reset_n, num_errors, comparisons} = '0;
    repeat (6) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    spi_cases();
    b_inputs();
    c_cases();
    summarize();
  end
endmodule // tb
